// ### lbd_pkg.sv
// shared constants and types for the led bypass dimming and fault monitor
package lbd_pkg;
  localparam int          NUM_SW          = 12;
  localparam int          CNT_W           = 12;
  localparam int          DATA_W          = 13;
  localparam int          ADDR_W          = 7;
  localparam int          DIV_W           = 2;
  // register offsets
  localparam logic [6:0]  ADDR_GEN_CFG    = 7'h03;
  localparam logic [6:0]  ADDR_MASK_CFG   = 7'h04;
  localparam logic [6:0]  ADDR_GEN_STAT   = 7'h05;
  localparam logic [6:0]  ADDR_OPEN_LED   = 7'h06;
  localparam logic [6:0]  ADDR_OPEN_TRACE = 7'h07;
  localparam logic [6:0]  ADDR_OVERRIDE   = 7'h08;
  localparam logic [6:0]  ADDR_SHORT_LED  = 7'h09;
  localparam logic [6:0]  ADDR_PHASE_BASE = 7'h10;
  localparam logic [6:0]  ADDR_DUTY_BASE  = 7'h20;
  // general_config fields
  localparam int          GC_CLK_SEL_LSB  = 0;
  localparam int          GC_DIV_LSB      = 2;
  localparam int          GC_RUN_EN_BIT   = 4;
  // fault_mask_config fields
  localparam int          MK_OPEN_LED_BIT = 0;
  localparam int          MK_SHORT_BIT    = 1;
  localparam int          MK_TRACE_BIT    = 2;
  localparam int          MK_WARN_BIT     = 3;
  localparam int          MK_SHDN_OPEN_BIT = 4;
  // general_status fields
  localparam int          GS_WARN_BIT     = 0;
  localparam int          GS_SHDN_BIT     = 1;
  localparam int          GS_OPEN_LED_BIT = 2;
  localparam int          GS_SHORT_BIT    = 3;
  localparam int          GS_TRACE_BIT    = 4;
  localparam logic [12:0] REG_RESET       = 13'h0000;
  // timing
  localparam longint      SYS_CLK_HZ      = 50000000;
  localparam longint      INT_OSC_HZ      = 8192000;
  localparam int          OSC_ACC_W       = 27;
  localparam logic [26:0] OSC_ACC_STEP    = 27'(INT_OSC_HZ);
  localparam logic [26:0] OSC_ACC_WRAP    = 27'(SYS_CLK_HZ);

  typedef enum logic [1:0] {
    LBD_CLK_INT_NOPIN = 2'b00,
    LBD_CLK_INT_OUT   = 2'b01,
    LBD_CLK_EXT_IN    = 2'b10,
    LBD_CLK_RSVD      = 2'b11
  } lbd_clk_sel_t;
endpackage : lbd_pkg

// ### lbd_clk_gen.sv
// pwm clock source: internal oscillator model, source select and divider
`timescale 1ns/100ps
module lbd_clk_gen
  import lbd_pkg::*;
(
  input  wire logic               clock_i,
  input  wire logic               resetn_i,
  input  wire logic               ce_i,
  input  wire logic               run_i,
  input  wire lbd_pkg::lbd_clk_sel_t clk_sel_i,
  input  wire logic [1:0]         div_i,
  input  wire logic               ext_edge_i,
  output logic                    osc_level_o,
  output logic                    pwm_tick_o
);
  import lbd_pkg::*;

  logic [OSC_ACC_W-1:0] acc_r;
  logic [OSC_ACC_W-1:0] acc_sum;
  logic                 osc_tick;
  logic                 src_tick;
  logic [2:0]           div_cnt_r;
  logic [2:0]           div_last;

  // fractional accumulator approximates the oscillator from the system clock
  assign acc_sum  = acc_r + OSC_ACC_STEP;
  assign osc_tick = (acc_sum >= OSC_ACC_WRAP);
  assign src_tick = (clk_sel_i == LBD_CLK_EXT_IN) ? ext_edge_i : osc_tick;
  assign div_last = 3'((4'h1 << div_i) - 4'h1);

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      acc_r <= '0;
    else if (ce_i)
      acc_r <= osc_tick ? acc_sum - OSC_ACC_WRAP : acc_sum;
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      osc_level_o <= 1'b0;
    else if (ce_i && osc_tick)
      osc_level_o <= ~osc_level_o;
  end

  // divide ratio 1, 2, 4 or 8 applied to either source
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      div_cnt_r  <= 3'h0;
      pwm_tick_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pwm_tick_o <= 1'b0;
      if (!run_i)
        div_cnt_r <= 3'h0;
      else if (src_tick)
      begin
        if (div_cnt_r >= div_last)
        begin
          div_cnt_r  <= 3'h0;
          pwm_tick_o <= 1'b1;
        end
        else
          div_cnt_r <= div_cnt_r + 3'h1;
      end
    end
  end
endmodule : lbd_clk_gen

// ### lbd_bypass_ctrl.sv
// led bypass switch pwm, fault detection, thermal handling and register file
`timescale 1ns/100ps
module lbd_bypass_ctrl
  import lbd_pkg::*;
#(
  parameter int NSW = lbd_pkg::NUM_SW
)
(
  input  wire logic                       clock_i,
  input  wire logic                       resetn_i,
  input  wire logic                       ce_i,
  input  wire logic                       en_i,
  input  wire logic [lbd_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  input  wire logic [lbd_pkg::DATA_W-1:0] reg_wdata_i,
  output logic      [lbd_pkg::DATA_W-1:0] reg_rdata_o,
  input  wire logic [NSW-1:0]             open_cmp_i,
  input  wire logic [NSW-1:0]             short_cmp_i,
  input  wire logic [NSW-1:0]             trace_low_i,
  input  wire logic                       temp_warn_i,
  input  wire logic                       temp_shdn_i,
  input  wire logic                       clk_pin_i,
  output logic                            clk_pin_o,
  output logic                            clk_pin_oe_o,
  output logic                            fault_out_n_o,
  output logic                            fault_out_n_oe_o,
  output logic      [NSW-1:0]             bypass_on_o
);
  import lbd_pkg::*;

  localparam int SYNC_W = 3 * NSW + 4;

  logic [SYNC_W-1:0]     sync1_r;
  logic [SYNC_W-1:0]     sync2_r;
  logic                  clk_pin_d3_r;
  logic [NSW-1:0]        open_cmp_s;
  logic [NSW-1:0]        short_cmp_s;
  logic [NSW-1:0]        trace_low_s;
  logic                  warn_s;
  logic                  shdn_s;
  logic                  en_s;
  logic                  clk_pin_s;
  logic                  ext_edge;

  logic [DATA_W-1:0]     gen_cfg_r;
  logic [DATA_W-1:0]     mask_cfg_r;
  logic [NSW-1:0]        override_r;
  logic [CNT_W-1:0]      phase_r [NSW];
  logic [CNT_W-1:0]      duty_r  [NSW];
  logic [NSW-1:0]        open_led_st_r;
  logic [NSW-1:0]        short_st_r;
  logic [NSW-1:0]        trace_st_r;
  logic                  warn_flag_r;
  logic                  shdn_flag_r;
  logic [DATA_W-1:0]     rdata_nxt;
  logic [DATA_W-1:0]     gen_stat;

  logic [CNT_W-1:0]      cnt_r;
  logic                  pwm_tick;
  logic                  tick_ok;
  logic                  run;
  logic                  osc_level;
  lbd_clk_sel_t          clk_sel;
  logic [NSW-1:0]        off_r;
  logic [NSW-1:0]        ol_hold_r;
  logic [NSW-1:0]        eff_open;
  logic [NSW-1:0]        open_req;
  logic [NSW-1:0]        close_req;
  logic [NSW-1:0]        ol_set;
  logic [NSW-1:0]        sh_set;
  logic [NSW-1:0]        tr_set;
  logic                  det_en;
  logic                  rd_gen;
  logic                  fault_any;

  // two-stage synchronisers for every pin and analog comparator
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync1_r      <= '0;
      sync2_r      <= '0;
      clk_pin_d3_r <= 1'b0;
    end
    else if (ce_i)
    begin
      sync1_r      <= {clk_pin_i, en_i, temp_shdn_i, temp_warn_i, trace_low_i, short_cmp_i, open_cmp_i};
      sync2_r      <= sync1_r;
      clk_pin_d3_r <= clk_pin_s;
    end
  end

  assign open_cmp_s  = sync2_r[NSW-1:0];
  assign short_cmp_s = sync2_r[2*NSW-1:NSW];
  assign trace_low_s = sync2_r[3*NSW-1:2*NSW];
  assign warn_s      = sync2_r[3*NSW];
  assign shdn_s      = sync2_r[3*NSW+1];
  assign en_s        = sync2_r[3*NSW+2];
  assign clk_pin_s   = sync2_r[3*NSW+3];
  assign ext_edge    = clk_pin_s & ~clk_pin_d3_r;

  assign clk_sel = lbd_clk_sel_t'(gen_cfg_r[GC_CLK_SEL_LSB +: 2]);
  assign run     = en_s & gen_cfg_r[GC_RUN_EN_BIT];
  assign det_en  = run & ~shdn_flag_r;
  assign rd_gen  = reg_rd_i && (reg_addr_i == ADDR_GEN_STAT);

  lbd_clk_gen u_clk_gen (
    .clock_i     (clock_i),
    .resetn_i    (resetn_i),
    .ce_i        (ce_i),
    .run_i       (en_s),
    .clk_sel_i   (clk_sel),
    .div_i       (gen_cfg_r[GC_DIV_LSB +: DIV_W]),
    .ext_edge_i  (ext_edge),
    .osc_level_o (osc_level),
    .pwm_tick_o  (pwm_tick)
  );

  // counter and switch states freeze during shutdown so operation resumes in place
  assign tick_ok = pwm_tick & ~shdn_flag_r;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cnt_r <= '0;
    else if (ce_i)
    begin
      if (!en_s)
        cnt_r <= '0;
      else if (tick_ok)
        cnt_r <= cnt_r + 1'b1;
    end
  end

  // configuration registers; enable low restores defaults
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      gen_cfg_r  <= REG_RESET;
      mask_cfg_r <= REG_RESET;
      override_r <= '0;
    end
    else if (ce_i)
    begin
      if (!en_s)
      begin
        gen_cfg_r  <= REG_RESET;
        mask_cfg_r <= REG_RESET;
        override_r <= '0;
      end
      else if (reg_wr_i)
      begin
        if (reg_addr_i == ADDR_GEN_CFG)
          gen_cfg_r <= reg_wdata_i;
        if (reg_addr_i == ADDR_MASK_CFG)
          mask_cfg_r <= reg_wdata_i;
        if (reg_addr_i == ADDR_OVERRIDE)
          override_r <= reg_wdata_i[NSW-1:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NSW; gi++)
    begin : g_sw
      logic [CNT_W-1:0] end_cnt;

      // off window closes on the first count past phase plus duty
      assign end_cnt       = phase_r[gi] + duty_r[gi] + 1'b1;
      assign open_req[gi]  = tick_ok && run && (cnt_r == phase_r[gi]) && (duty_r[gi] != '0);
      assign close_req[gi] = tick_ok && run && (cnt_r == end_cnt) && !open_req[gi];
      assign eff_open[gi]  = off_r[gi] & ~ol_hold_r[gi] & ~override_r[gi];
      assign ol_set[gi]    = det_en & eff_open[gi] & open_cmp_s[gi];
      assign sh_set[gi]    = det_en & close_req[gi] & eff_open[gi] & short_cmp_s[gi];
      assign tr_set[gi]    = det_en & open_req[gi] & ~eff_open[gi] & trace_low_s[gi];

      always_ff @(posedge clock_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          phase_r[gi] <= '0;
          duty_r[gi]  <= '0;
        end
        else if (ce_i)
        begin
          if (!en_s)
          begin
            phase_r[gi] <= '0;
            duty_r[gi]  <= '0;
          end
          else if (reg_wr_i && reg_addr_i == ADDR_PHASE_BASE + 7'(gi))
            phase_r[gi] <= reg_wdata_i[CNT_W-1:0];
          else if (reg_wr_i && reg_addr_i == ADDR_DUTY_BASE + 7'(gi))
            duty_r[gi] <= reg_wdata_i[CNT_W-1:0];
        end
      end

      // short and trace faults never touch the sequencer state
      always_ff @(posedge clock_i or negedge resetn_i)
      begin
        if (!resetn_i)
          off_r[gi] <= 1'b0;
        else if (ce_i)
        begin
          if (!run)
            off_r[gi] <= 1'b0;
          else if (open_req[gi])
            off_r[gi] <= 1'b1;
          else if (close_req[gi])
            off_r[gi] <= 1'b0;
        end
      end

      // protective close held until the sequencer asks to open again
      always_ff @(posedge clock_i or negedge resetn_i)
      begin
        if (!resetn_i)
          ol_hold_r[gi] <= 1'b0;
        else if (ce_i)
        begin
          if (!run || open_req[gi])
            ol_hold_r[gi] <= 1'b0;
          else if (ol_set[gi])
            ol_hold_r[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // per-switch status; a new event beats the read clear
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      open_led_st_r <= '0;
      short_st_r    <= '0;
      trace_st_r    <= '0;
    end
    else if (ce_i)
    begin
      if (!en_s)
      begin
        open_led_st_r <= '0;
        short_st_r    <= '0;
        trace_st_r    <= '0;
      end
      else
      begin
        open_led_st_r <= (reg_rd_i && reg_addr_i == ADDR_OPEN_LED ? '0 : open_led_st_r) | ol_set;
        short_st_r    <= (reg_rd_i && reg_addr_i == ADDR_SHORT_LED ? '0 : short_st_r) | sh_set;
        trace_st_r    <= (reg_rd_i && reg_addr_i == ADDR_OPEN_TRACE ? '0 : trace_st_r) | tr_set;
      end
    end
  end

  // thermal flags clear on status read only once below the warning level
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      warn_flag_r <= 1'b0;
      shdn_flag_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!en_s)
      begin
        warn_flag_r <= 1'b0;
        shdn_flag_r <= 1'b0;
      end
      else
      begin
        warn_flag_r <= warn_s | (warn_flag_r & ~rd_gen);
        shdn_flag_r <= shdn_s | (shdn_flag_r & ~(rd_gen & ~warn_s));
      end
    end
  end

  always_comb
  begin
    gen_stat                  = '0;
    gen_stat[GS_WARN_BIT]     = warn_flag_r;
    gen_stat[GS_SHDN_BIT]     = shdn_flag_r;
    gen_stat[GS_OPEN_LED_BIT] = |open_led_st_r;
    gen_stat[GS_SHORT_BIT]    = |short_st_r;
    gen_stat[GS_TRACE_BIT]    = |trace_st_r;
  end

  assign fault_any = (warn_flag_r & ~mask_cfg_r[MK_WARN_BIT])
                   | shdn_flag_r
                   | (gen_stat[GS_OPEN_LED_BIT] & ~mask_cfg_r[MK_OPEN_LED_BIT])
                   | (gen_stat[GS_SHORT_BIT] & ~mask_cfg_r[MK_SHORT_BIT])
                   | (gen_stat[GS_TRACE_BIT] & ~mask_cfg_r[MK_TRACE_BIT]);

  always_comb
  begin
    rdata_nxt = '0;
    case (reg_addr_i)
      ADDR_GEN_CFG:    rdata_nxt = gen_cfg_r;
      ADDR_MASK_CFG:   rdata_nxt = mask_cfg_r;
      ADDR_GEN_STAT:   rdata_nxt = gen_stat;
      ADDR_OPEN_LED:   rdata_nxt = DATA_W'(open_led_st_r);
      ADDR_OPEN_TRACE: rdata_nxt = DATA_W'(trace_st_r);
      ADDR_OVERRIDE:   rdata_nxt = DATA_W'(override_r);
      ADDR_SHORT_LED:  rdata_nxt = DATA_W'(short_st_r);
      default:
      begin
        for (int k = 0; k < NSW; k++)
        begin
          if (reg_addr_i == ADDR_PHASE_BASE + 7'(k))
            rdata_nxt = DATA_W'(phase_r[k]);
          if (reg_addr_i == ADDR_DUTY_BASE + 7'(k))
            rdata_nxt = DATA_W'(duty_r[k]);
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      reg_rdata_o <= '0;
    else if (ce_i && reg_rd_i)
      reg_rdata_o <= rdata_nxt;
  end

  // pin drivers; bypass on means the switch conducts and the led is dark
  assign fault_out_n_o = 1'b0;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      fault_out_n_oe_o <= 1'b0;
      bypass_on_o      <= '1;
      clk_pin_o        <= 1'b0;
      clk_pin_oe_o     <= 1'b0;
    end
    else if (ce_i)
    begin
      fault_out_n_oe_o <= fault_any;
      if (!en_s)
        bypass_on_o <= '1;
      else if (shdn_flag_r)
        bypass_on_o <= {NSW{~mask_cfg_r[MK_SHDN_OPEN_BIT]}};
      else
        bypass_on_o <= ~eff_open;
      clk_pin_o    <= osc_level;
      clk_pin_oe_o <= en_s && (clk_sel == LBD_CLK_INT_OUT);
    end
  end
endmodule : lbd_bypass_ctrl

// ### lbd_bypass_ctrl_props.sv
// concurrent checks on the bypass controller ports
`timescale 1ns/100ps
module lbd_bypass_ctrl_props
  import lbd_pkg::*;
#(
  parameter int NSW = 12
)
(
  input wire logic                       clock_i,
  input wire logic                       resetn_i,
  input wire logic                       ce_i,
  input wire logic                       en_i,
  input wire logic [lbd_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic                       reg_wr_i,
  input wire logic                       reg_rd_i,
  input wire logic [lbd_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic [lbd_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic [NSW-1:0]             open_cmp_i,
  input wire logic [NSW-1:0]             short_cmp_i,
  input wire logic [NSW-1:0]             trace_low_i,
  input wire logic                       temp_warn_i,
  input wire logic                       temp_shdn_i,
  input wire logic                       clk_pin_i,
  input wire logic                       clk_pin_o,
  input wire logic                       clk_pin_oe_o,
  input wire logic                       fault_out_n_o,
  input wire logic                       fault_out_n_oe_o,
  input wire logic [NSW-1:0]             bypass_on_o
);
  logic [2:0] en_cnt_r;
  logic [1:0] quiet_r;
  logic       en_ok;

  // enable must have crossed its synchroniser before port behaviour is judged
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      en_cnt_r <= 3'h0;
    else if (!en_i)
      en_cnt_r <= 3'h0;
    else if (ce_i && en_cnt_r != 3'h4)
      en_cnt_r <= en_cnt_r + 3'h1;
  end

  // reads and mask writes may legally drop the fault pin
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
      quiet_r <= 2'h0;
    else if (reg_rd_i || reg_wr_i)
      quiet_r <= 2'h0;
    else if (quiet_r != 2'h3)
      quiet_r <= quiet_r + 2'h1;
  end

  assign en_ok = en_i && ce_i && en_cnt_r == 3'h4;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_open_seen;
    (en_ok && !temp_shdn_i && open_cmp_i[0] && !bypass_on_o[0])[*4];
  endsequence
  sequence s_shdn_held;
    (en_ok && temp_shdn_i)[*4];
  endsequence
  sequence s_en_low;
    (ce_i && !en_i)[*8];
  endsequence

  AST_FAULT_PIN_LOW: assert property (fault_out_n_o == 1'b0)
    else $error("fault pin drives a high level");
  AST_RESET_REL: assert property ($rose(resetn_i) |-> (&bypass_on_o) && !fault_out_n_oe_o && !clk_pin_oe_o)
    else $error("outputs not at defaults after reset");
  AST_EN_LOW: assert property (s_en_low |-> (&bypass_on_o) && !fault_out_n_oe_o)
    else $error("enable low did not close switches");
  AST_RDATA_HOLD: assert property (en_ok && !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
  AST_UNMAPPED: assert property (en_ok && reg_rd_i && reg_addr_i == 7'h7F |=> reg_rdata_o == 13'h0000)
    else $error("unmapped read not zero");
  AST_OPEN_CLOSE: assert property (s_open_seen |-> ##[0:2] bypass_on_o[0])
    else $error("open led did not close switch");
  AST_SHDN_FAULT: assert property (s_shdn_held |-> ##[0:2] fault_out_n_oe_o)
    else $error("shutdown did not pull fault");
  AST_SHDN_STATIC: assert property (s_shdn_held ##1 (en_ok && temp_shdn_i)[*4] |=> $stable(bypass_on_o))
    else $error("switches moved during shutdown");
  AST_FAULT_HOLD: assert property (fault_out_n_oe_o && en_ok && quiet_r == 2'h3 |=> fault_out_n_oe_o)
    else $error("fault released without a read");
endmodule : lbd_bypass_ctrl_props

// ### lbd_far_model.sv
// far side: clock pin with pull-down, external clock source, fault line pull-up
`timescale 1ns/100ps
module lbd_far_model
(
  input  wire logic clock_i,
  input  wire logic ext_run_i,
  input  wire logic dev_clk_i,
  input  wire logic dev_clk_oe_i,
  input  wire logic dev_fault_i,
  input  wire logic dev_fault_oe_i,
  output logic      pin_clk_o,
  output logic      fault_line_o
);
  logic ext_clk_r;

  // source stands low when not in use so the pin rests on its pull-down
  always_ff @(posedge clock_i)
  begin
    ext_clk_r <= ext_run_i ? ~ext_clk_r : 1'b0;
  end

  assign pin_clk_o    = dev_clk_oe_i ? dev_clk_i : (ext_run_i & ext_clk_r);
  assign fault_line_o = dev_fault_oe_i ? dev_fault_i : 1'b1;
endmodule : lbd_far_model

// ### tb_led_bypass_dimming_fault_monitor.sv
// self-checking bench for the bypass controller
`timescale 1ns/100ps
module tb_led_bypass_dimming_fault_monitor;
  import lbd_pkg::*;
  localparam int NSW = 12;
  logic            clock_i, resetn_i, ce_i, en_i, reg_wr_i, reg_rd_i, temp_warn_i, temp_shdn_i;
  logic            clk_pin_i, clk_pin_o, clk_pin_oe_o, fault_out_n_o, fault_out_n_oe_o, ext_run, fault_line;
  logic [6:0]      reg_addr_i;
  logic [12:0]     reg_wdata_i, reg_rdata_o;
  logic [NSW-1:0]  open_cmp_i, short_cmp_i, trace_low_i, bypass_on_o;
  int              mismatches = 0;
  int              num_checks = 0;
  int              n, m;

  lbd_bypass_ctrl #(.NSW(NSW)) dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i), .en_i(en_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .open_cmp_i(open_cmp_i), .short_cmp_i(short_cmp_i), .trace_low_i(trace_low_i),
    .temp_warn_i(temp_warn_i), .temp_shdn_i(temp_shdn_i), .clk_pin_i(clk_pin_i), .clk_pin_o(clk_pin_o),
    .clk_pin_oe_o(clk_pin_oe_o), .fault_out_n_o(fault_out_n_o), .fault_out_n_oe_o(fault_out_n_oe_o),
    .bypass_on_o(bypass_on_o));
  lbd_far_model u_far (.clock_i(clock_i), .ext_run_i(ext_run), .dev_clk_i(clk_pin_o), .dev_clk_oe_i(clk_pin_oe_o),
    .dev_fault_i(fault_out_n_o), .dev_fault_oe_i(fault_out_n_oe_o), .pin_clk_o(clk_pin_i), .fault_line_o(fault_line));

  task automatic end_of_test();
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask : tick

  task automatic wr(input logic [6:0] a, input logic [12:0] d);
    @(posedge clock_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clock_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [12:0] exp);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clock_i);
    reg_rd_i   <= 1'b0;
    #1;
    chk("read data", exp, reg_rdata_o);
  endtask : rd

  // counts cycles until the switch reaches the level; a miss is reported as a mismatch
  task automatic wait_sw(input int i, input logic v, input int lim, output int c);
    c = 0;
    do
    begin
      @(posedge clock_i);
      #1;
      c++;
    end while (bypass_on_o[i] !== v && c < lim);
    chk("switch level", 13'(v), 13'(bypass_on_o[i]));
  endtask : wait_sw

  task automatic t_defaults();
    for (int a = 3; a <= 9; a++)
      rd(7'(a), 13'h0000);
    rd(7'h7F, 13'h0000);
    wr(ADDR_GEN_STAT, 13'h1FFF);
    rd(ADDR_GEN_STAT, 13'h0000);
    wr(ADDR_OVERRIDE, 13'h0FFF);
    rd(ADDR_OVERRIDE, 13'h0FFF);
    wr(ADDR_OVERRIDE, 13'h0000);
    for (int s = 0; s < 4; s++)
    begin
      wr(ADDR_GEN_CFG, 13'(s));
      tick(3);
      chk("clock pin enable", 13'(s == 1), 13'(clk_pin_oe_o));
      if (s == 1)
      begin
        // oscillator edge comes at least every seven system clocks
        m = 0;
        n = int'(clk_pin_o);
        while (clk_pin_o === n[0] && m < 8)
        begin
          tick(1);
          m++;
        end
        chk("clock pin toggle", 13'h0001, 13'(m < 8));
      end
    end
  endtask : t_defaults

  task automatic t_pwm();
    wr(ADDR_PHASE_BASE, 13'h0002);
    wr(ADDR_DUTY_BASE, 13'h0003);
    ext_run <= 1'b1;
    for (int dv = 1; dv >= 0; dv--)
    begin
      wr(ADDR_GEN_CFG, 13'h0012 | 13'(dv << 2));
      wait_sw(0, 1'b1, 100, n);
      wait_sw(0, 1'b0, 17000, n);
      wait_sw(0, 1'b1, 100, n);
      chk("off width", 13'(8 << dv), 13'(n));
    end
    wait_sw(0, 1'b0, 9000, m);
    chk("dimming period", 13'h1FFF, 13'(n + m - 1));
  endtask : t_pwm

  task automatic t_open();
    wr(ADDR_DUTY_BASE, 13'h0100);
    for (int mk = 0; mk < 2; mk++)
    begin
      wr(ADDR_MASK_CFG, 13'(mk));
      wait_sw(0, 1'b1, 600, n);
      wait_sw(0, 1'b0, 9000, n);
      @(posedge clock_i);
      open_cmp_i <= 12'h001;
      wait_sw(0, 1'b1, 8, n);
      tick(2);
      chk("fault drive", 13'(mk == 0), 13'(fault_out_n_oe_o));
      @(posedge clock_i);
      open_cmp_i <= 12'h000;
      rd(ADDR_GEN_STAT, 13'h0004);
      rd(ADDR_OPEN_LED, 13'h0001);
      tick(3);
      chk("fault drive", 13'h0000, 13'(fault_out_n_oe_o));
    end
  endtask : t_open

  task automatic t_short_trace();
    wr(ADDR_MASK_CFG, 13'h0000);
    wr(7'h11, 13'h0000);
    wr(7'h21, 13'h000A);
    wr(7'h12, 13'h0000);
    wr(7'h22, 13'h000A);
    short_cmp_i <= 12'h002;
    trace_low_i <= 12'h004;
    for (int mk = 0; mk < 2; mk++)
    begin
      wait_sw(1, 1'b1, 9000, n);
      wait_sw(1, 1'b0, 9000, n);
      wait_sw(1, 1'b1, 100, n);
      chk("on-pulse width", 13'd22, 13'(n));
      tick(4);
      chk("fault drive", 13'(mk == 0), 13'(fault_out_n_oe_o));
      if (mk == 0)
        rd(ADDR_GEN_STAT, 13'h0018);
      rd(ADDR_SHORT_LED, 13'h0002);
      rd(ADDR_OPEN_TRACE, 13'h0004);
      wr(ADDR_MASK_CFG, 13'h0006);
    end
    short_cmp_i <= 12'h000;
    trace_low_i <= 12'h000;
    tick(2);
  endtask : t_short_trace

  task automatic t_thermal();
    wr(ADDR_MASK_CFG, 13'h0000);
    temp_warn_i <= 1'b1;
    tick(6);
    chk("fault line", 13'h0000, 13'(fault_line));
    rd(ADDR_GEN_STAT, 13'h0001);
    rd(ADDR_GEN_STAT, 13'h0001);
    @(posedge clock_i);
    temp_warn_i <= 1'b0;
    tick(4);
    chk("fault drive", 13'h0001, 13'(fault_out_n_oe_o));
    rd(ADDR_GEN_STAT, 13'h0001);
    rd(ADDR_GEN_STAT, 13'h0000);
    tick(3);
    chk("fault drive", 13'h0000, 13'(fault_out_n_oe_o));
    for (int op = 0; op < 2; op++)
    begin
      wr(ADDR_MASK_CFG, 13'(op << 4));
      temp_warn_i <= 1'b1;
      temp_shdn_i <= 1'b1;
      tick(8);
      chk("forced switches", op ? 13'h0000 : 13'h0FFF, {1'b0, bypass_on_o});
      @(posedge clock_i);
      temp_warn_i <= 1'b0;
      temp_shdn_i <= 1'b0;
      tick(4);
      chk("forced switches", op ? 13'h0000 : 13'h0FFF, {1'b0, bypass_on_o});
      rd(ADDR_GEN_STAT, 13'h0003);
      rd(ADDR_GEN_STAT, 13'h0000);
    end
    wait_sw(0, 1'b1, 600, n);
    wait_sw(0, 1'b0, 9000, n);
  endtask : t_thermal

  task automatic t_enable();
    @(posedge clock_i);
    en_i <= 1'b0;
    tick(8);
    chk("switches on enable low", 13'h0FFF, {1'b0, bypass_on_o});
    @(posedge clock_i);
    en_i <= 1'b1;
    tick(4);
    rd(ADDR_GEN_CFG, 13'h0000);
    rd(ADDR_DUTY_BASE, 13'h0000);
  endtask : t_enable

  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  initial
  begin
    repeat (90000) @(posedge clock_i);
    mismatches++;
    end_of_test();
  end

  initial
  begin
    {resetn_i, en_i, reg_wr_i, reg_rd_i, temp_warn_i, temp_shdn_i, ext_run} = '0;
    ce_i        = 1'b1;
    reg_addr_i  = 7'h00;
    reg_wdata_i = 13'h0000;
    open_cmp_i  = '0;
    short_cmp_i = '0;
    trace_low_i = '0;
    repeat (16) @(posedge clock_i);
    resetn_i <= 1'b1;
    en_i     <= 1'b1;
    tick(4);
    t_defaults();
    t_pwm();
    t_open();
    t_short_trace();
    t_thermal();
    t_enable();
    end_of_test();
  end
endmodule : tb_led_bypass_dimming_fault_monitor

bind lbd_bypass_ctrl lbd_bypass_ctrl_props #(.NSW(NSW)) u_props (.clock_i(clock_i), .resetn_i(resetn_i),
  .ce_i(ce_i), .en_i(en_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .open_cmp_i(open_cmp_i), .short_cmp_i(short_cmp_i),
  .trace_low_i(trace_low_i), .temp_warn_i(temp_warn_i), .temp_shdn_i(temp_shdn_i), .clk_pin_i(clk_pin_i),
  .clk_pin_o(clk_pin_o), .clk_pin_oe_o(clk_pin_oe_o), .fault_out_n_o(fault_out_n_o),
  .fault_out_n_oe_o(fault_out_n_oe_o), .bypass_on_o(bypass_on_o));
